// >>> include/cps_defines.svh
// Purpose: Timing counts and limits for the converter protection supervisor
// Assumes: 40 MHz system clock; timer_cap_input is the capacitor oscillator output
// Notes:   Tick counts scale with the capacitor; CPS_SS_TICKS, CPS_OVL_TICKS and CPS_PFC_OFF_TICKS are in oscillator ticks
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH

`define CPS_CLK_PERIOD_NS    25
`define CPS_CLK_MHZ          40
`define CPS_SHORT_TIME_US    16000
`define CPS_AUX_SAMPLE_NS    2000
`define CPS_AUX_SAMPLE_CYC   ((`CPS_AUX_SAMPLE_NS + `CPS_CLK_PERIOD_NS - 1) / `CPS_CLK_PERIOD_NS)
`define CPS_AUX_OVER_LAST    3'h3
`define CPS_OVL_RELEASE_LAST 2'h3
`define CPS_SS_TICKS         11'h00A
`define CPS_OVL_TICKS        11'h041
`define CPS_PFC_OFF_TICKS    11'h3FE

`endif

// >>> include/cps_pkg.sv
// Purpose: Types shared by the converter protection supervisor
// Assumes: Nothing beyond the defines header
// Notes:   Types only; all numbers live in cps_defines.svh
package cps_pkg;
  typedef logic [10:0] cps_tick_count_t;
  typedef enum logic [1:0] {CPS_GATE_WAIT, CPS_GATE_ON, CPS_GATE_SAMPLE} cps_gate_state_t;
endpackage

// >>> src/cps_tick_timer.sv
// Purpose: Counts capacitor oscillator ticks while a condition holds
// Assumes: tick is a one-cycle pulse per oscillator period
// Notes:   Count clears as soon as hold drops; done stays high while limit reached
module cps_tick_timer
  import cps_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      tick,
  input  wire logic                      hold,
  input  wire cps_pkg::cps_tick_count_t  limit,
  output logic                           done
);
  import cps_pkg::*;

  cps_tick_count_t count_reg;
  cps_tick_count_t count_next;
  wire             at_limit;

  assign at_limit   = (count_reg >= limit);
  assign count_next = !hold ? '0 : ((tick && !at_limit) ? count_reg + 11'h001 : count_reg);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      count_reg <= '0;
      done      <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done      <= hold && (count_next >= limit);
    end
  end
endmodule

// >>> src/cps_supervisor.sv
// Purpose: Protection supervisor deciding when the flyback gate may switch
// Assumes: All comparator inputs are synchronous to clock; trip inputs are pulses
// Notes:   Gate turns on only at a valley; no start-up pulse without a valley
`include "cps_defines.svh"

// Notes on behaviour
// - Short trip: feedback high over 16 ms while supply below 10 V.
// - Overload trip when feedback stays high past the overload debounce.
// - Overload debounce counted in capacitor oscillator ticks to ride through transients.
// - Overload latches off; release on the fourth supply-low trip.
// - Supply overvoltage stops the driver at once until next start trip.
// - Persisting supply overvoltage holds the latch set through each start trip, so the driver does not restart.
// - Each on-time starts at a falling aux crossing through 0.05 V.
// - Aux current sampled 2 us after every gate turn-off.
// - Sampled aux current above 300 uA marks an overvoltage event.
// - Four successive aux overvoltage cycles switch the power switch off.
// - Die over-temperature disables the driver until it cools past hysteresis.
// - External sense below 1.0 V stops the driver; recovers automatically.
// - Temperature sense bias source off whenever any protection stops switching.
// - Soft-start, overload and PFC-off debounces all scale with oscillator ticks.
// - Short, supply overvoltage and aux overvoltage latches clear at each start trip; overload clears only at its release.
module cps_supervisor
  import cps_pkg::*;
#(
  parameter int SHORT_CYCLES = `CPS_SHORT_TIME_US * `CPS_CLK_MHZ
)
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic feedback_comp_input,
  input  wire logic feedback_below_pfc_off,
  input  wire logic supply_below_10v,
  input  wire logic supply_over_limit,
  input  wire logic supply_low_trip,
  input  wire logic supply_start_trip,
  input  wire logic timer_cap_input,
  input  wire logic flyback_aux_sense,
  input  wire logic aux_current_over,
  input  wire logic current_sense_trip,
  input  wire logic die_over_temp,
  input  wire logic ext_temp_below_trip,
  output logic      flyback_gate_drive,
  output logic      flyback_enable,
  output logic      temp_bias_enable,
  output logic      soft_start_active,
  output logic      pfc_off_request,
  output logic      output_short_protect,
  output logic      overload_protect,
  output logic      overvoltage_protect,
  output logic      aux_overvoltage_protect
);
  import cps_pkg::*;

  localparam int SAMPLE_CYC = `CPS_AUX_SAMPLE_CYC;

  logic            cap_prev_reg;
  logic            aux_prev_reg;
  logic [19:0]     fb_cnt_reg;
  logic [19:0]     fb_cnt_next;
  logic [1:0]      ovl_cnt_reg;
  logic [2:0]      aux_cnt_reg;
  logic [2:0]      aux_cnt_next;
  logic [6:0]      sample_cnt_reg;
  cps_gate_state_t state_reg;
  cps_gate_state_t state_next;
  logic            ovl_done;
  logic            ss_done;

  wire cap_tick            = timer_cap_input && !cap_prev_reg;
  wire zero_current_detect = flyback_aux_sense && !aux_prev_reg;
  wire fb_at_max           = (fb_cnt_reg == 20'hFFFFF);
  wire short_set           = feedback_comp_input && supply_below_10v
                             && (fb_cnt_reg >= 20'(SHORT_CYCLES));
  wire ovl_release         = overload_protect && supply_low_trip
                             && (ovl_cnt_reg == `CPS_OVL_RELEASE_LAST);
  wire ovl_set             = ovl_done && !overload_protect;
  wire sample_point        = (state_reg == CPS_GATE_SAMPLE)
                             && (sample_cnt_reg == 7'(SAMPLE_CYC - 1));
  wire aux_event           = sample_point && aux_current_over;
  wire aux_trip            = aux_event && (aux_cnt_reg == `CPS_AUX_OVER_LAST);
  wire fault               = output_short_protect || overload_protect || overvoltage_protect
                             || supply_over_limit || aux_overvoltage_protect || die_over_temp
                             || ext_temp_below_trip;

  assign fb_cnt_next  = !feedback_comp_input ? 20'h00000
                        : (fb_at_max ? fb_cnt_reg : fb_cnt_reg + 20'h00001);
  assign aux_cnt_next = aux_overvoltage_protect ? 3'h0
                        : (!sample_point ? aux_cnt_reg
                        : (aux_current_over ? aux_cnt_reg + 3'h1 : 3'h0));

  // Debounce timers on oscillator ticks
  cps_tick_timer u_ovl_timer
  (
    .clock (clock),
    .rst_b (rst_b),
    .tick  (cap_tick),
    .hold  (feedback_comp_input && flyback_enable),
    .limit (`CPS_OVL_TICKS),
    .done  (ovl_done)
  );

  cps_tick_timer u_ss_timer
  (
    .clock (clock),
    .rst_b (rst_b),
    .tick  (cap_tick),
    .hold  (flyback_enable),
    .limit (`CPS_SS_TICKS),
    .done  (ss_done)
  );

  cps_tick_timer u_pfc_timer
  (
    .clock (clock),
    .rst_b (rst_b),
    .tick  (cap_tick),
    .hold  (feedback_below_pfc_off),
    .limit (`CPS_PFC_OFF_TICKS),
    .done  (pfc_off_request)
  );

  // Gate sequencing: valley turn-on, turn-off, post turn-off sample delay
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CPS_GATE_WAIT:
        if (!fault && zero_current_detect)
          state_next = CPS_GATE_ON;
      CPS_GATE_ON:
        if (fault || current_sense_trip)
          state_next = CPS_GATE_SAMPLE;
      CPS_GATE_SAMPLE:
        if (sample_point)
          state_next = CPS_GATE_WAIT;
      default:
        state_next = CPS_GATE_WAIT;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg      <= CPS_GATE_WAIT;
      sample_cnt_reg <= 7'h00;
      cap_prev_reg   <= 1'b0;
      aux_prev_reg   <= 1'b0;
      fb_cnt_reg     <= 20'h00000;
      aux_cnt_reg    <= 3'h0;
    end
    else
    begin
      state_reg      <= state_next;
      sample_cnt_reg <= (state_reg == CPS_GATE_SAMPLE) ? sample_cnt_reg + 7'h01 : 7'h00;
      cap_prev_reg   <= timer_cap_input;
      aux_prev_reg   <= flyback_aux_sense;
      fb_cnt_reg     <= fb_cnt_next;
      aux_cnt_reg    <= aux_cnt_next;
    end
  end

  // Protection latches; a set always wins over a start-trip clear
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      output_short_protect    <= 1'b0;
      overload_protect        <= 1'b0;
      ovl_cnt_reg             <= 2'h0;
      overvoltage_protect     <= 1'b0;
      aux_overvoltage_protect <= 1'b0;
    end
    else
    begin
      output_short_protect    <= short_set
                                 || (output_short_protect && !supply_start_trip);
      overload_protect        <= ovl_set
                                 || (overload_protect && !ovl_release);
      ovl_cnt_reg             <= !overload_protect ? 2'h0
                                 : (supply_low_trip ? ovl_cnt_reg + 2'h1 : ovl_cnt_reg);
      overvoltage_protect     <= supply_over_limit
                                 || (overvoltage_protect && !supply_start_trip);
      aux_overvoltage_protect <= aux_trip
                                 || (aux_overvoltage_protect && !supply_start_trip);
    end
  end

  // Registered outputs
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      flyback_gate_drive <= 1'b0;
      flyback_enable     <= 1'b0;
      temp_bias_enable   <= 1'b0;
      soft_start_active  <= 1'b0;
    end
    else
    begin
      flyback_gate_drive <= (state_next == CPS_GATE_ON);
      flyback_enable     <= !fault;
      temp_bias_enable   <= !fault;
      soft_start_active  <= flyback_enable && !ss_done;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  short_cause_a: assert property ($rose(output_short_protect) |->
    $past(feedback_comp_input) && $past(supply_below_10v)
    && ($past(fb_cnt_reg) >= 20'(SHORT_CYCLES)))
    else $error("short protection set without its cause");
  ovl_cause_a: assert property ($rose(overload_protect) |-> $past(ovl_done))
    else $error("overload set without debounce expiry");
  ovl_hold_a: assert property (overload_protect && !ovl_release |=> overload_protect)
    else $error("overload released before fourth low trip");
  ovl_release_a: assert property (ovl_release && !ovl_done |=> !overload_protect)
    else $error("overload not released at fourth low trip");
  vcc_over_a: assert property (supply_over_limit |=> overvoltage_protect && !flyback_enable)
    else $error("supply overvoltage did not stop driver");
  vcc_hiccup_a: assert property (overvoltage_protect && !supply_start_trip |=> overvoltage_protect)
    else $error("supply overvoltage cleared without start trip");
  valley_on_a: assert property ($rose(flyback_gate_drive) |-> $past(zero_current_detect))
    else $error("gate on without valley");
  aux_sample_a: assert property ($fell(flyback_gate_drive) |-> ##79 sample_point)
    else $error("aux sample not 2 us after turn-off");
  aux_count_a: assert property ($rose(aux_overvoltage_protect) |->
    $past(aux_cnt_reg) == 3'h3 && $past(aux_current_over))
    else $error("aux overvoltage latched before four events");
  die_temp_a: assert property (die_over_temp |=> !flyback_enable && !flyback_gate_drive)
    else $error("die over-temperature did not stop driver");
  ext_temp_a: assert property (ext_temp_below_trip |=> !temp_bias_enable && !flyback_enable)
    else $error("external over-temperature did not stop driver");
  gate_enable_a: assert property (flyback_gate_drive |-> flyback_enable)
    else $error("gate driven while protection active");

  ovl_release_c: cover property (ovl_release);
  vcc_hiccup_c: cover property (overvoltage_protect ##1 !overvoltage_protect ##[1:50] overvoltage_protect);
  aux_trip_c: cover property ($rose(aux_overvoltage_protect));
  valley_c: cover property ($rose(flyback_gate_drive));
endmodule

// >>> sim/cps_stage_model.sv
// Purpose: Power stage stand-in: timer oscillator, valleys, peak current
// Assumes: Changes its outputs at the falling clock edge
// Notes:   Valley comes 100 cycles after the gate falls, while enabled
module cps_stage_model
(
  input  wire logic       clock,
  input  wire logic       osc_run,
  input  wire logic       valley_run,
  input  wire logic [7:0] on_len,
  input  wire logic       gate,
  output logic            timer_cap_input,
  output logic            flyback_aux_sense,
  output logic            current_sense_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  int osc_cnt = 0;
  int low_cnt = 0;
  int on_cnt  = 0;
  initial
  begin
    timer_cap_input = 1'b0;
    flyback_aux_sense = 1'b0;
    current_sense_trip = 1'b0;
    forever
    begin
      @(negedge clock);
      osc_cnt = osc_run ? osc_cnt + 1 : 0;
      timer_cap_input = osc_cnt[1];
      on_cnt = gate ? on_cnt + 1 : 0;
      current_sense_trip = gate && (on_cnt >= int'(on_len));
      low_cnt = (gate || !valley_run) ? 0 : low_cnt + 1;
      flyback_aux_sense = (low_cnt >= 100) && (low_cnt < 103);
      if (low_cnt >= 103)
        low_cnt = 0;
    end
  end
endmodule

// >>> sim/cps_supervisor_bench.sv
// Purpose: Self-checking bench for the protection supervisor
// Assumes: Short count shortened to 20 cycles
// Notes:   Result order {soft, gate, enable, bias, short, overload, supply over, aux, pfc}
module cps_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 0, rst_b = 0, feedback_comp_input = 0;
  logic       feedback_below_pfc_off = 0, supply_below_10v = 0;
  logic       supply_over_limit = 0, supply_low_trip = 0, supply_start_trip = 0;
  logic       aux_current_over = 0, die_over_temp = 0, ext_temp_below_trip = 0;
  logic       osc_run = 0, valley_run = 0;
  logic [7:0] on_len = 8'h14;
  logic [7:0] pat = 8'hF7;
  logic       tick, aux, trip, gate, en, bias, ss, pfc, sh_p, ol_p, ov_p, ax_p;
  logic [8:0] exp_q[$];
  logic [8:0] msk_q[$];
  int         mismatches = 0;
  int         checked = 0;
  int         run, cnt;
  integer     seed = 32'h3D9A7FAB;
  event       smp;
  wire  [8:0] obs = {ss, gate, en, bias, sh_p, ol_p, ov_p, ax_p, pfc};

  cps_supervisor #(.SHORT_CYCLES(20)) dut (.clock(clock), .rst_b(rst_b),
    .feedback_comp_input(feedback_comp_input),
    .feedback_below_pfc_off(feedback_below_pfc_off),
    .supply_below_10v(supply_below_10v), .supply_over_limit(supply_over_limit),
    .supply_low_trip(supply_low_trip), .supply_start_trip(supply_start_trip),
    .timer_cap_input(tick), .flyback_aux_sense(aux),
    .aux_current_over(aux_current_over), .current_sense_trip(trip),
    .die_over_temp(die_over_temp), .ext_temp_below_trip(ext_temp_below_trip),
    .flyback_gate_drive(gate), .flyback_enable(en), .temp_bias_enable(bias),
    .soft_start_active(ss), .pfc_off_request(pfc), .output_short_protect(sh_p),
    .overload_protect(ol_p), .overvoltage_protect(ov_p),
    .aux_overvoltage_protect(ax_p));

  cps_stage_model stage (.clock(clock), .osc_run(osc_run), .valley_run(valley_run),
    .on_len(on_len), .gate(gate), .timer_cap_input(tick),
    .flyback_aux_sense(aux), .current_sense_trip(trip));

  initial
  forever #12.5 clock = ~clock;

  task automatic note(input logic [8:0] e, input logic [8:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    -> smp;
    @(negedge clock);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    @(negedge clock);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  forever
  begin
    @(smp);
    checked++;
    if ((obs & msk_q[0]) !== exp_q[0])
    begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, obs & msk_q[0], exp_q[0]);
    end
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end

  initial
  begin
    repeat (20000) @(negedge clock);
    mismatches++;
    complete_run();
  end

  initial
  begin
    idle(20);
    rst_b = 1'b1;
    idle(2);
    note(9'h160, 9'h17F);
    for (run = 0; run < 2; run++)
    begin
      {ext_temp_below_trip, die_over_temp} = 2'(run + 1);
      idle(2);
      note(9'h000, 9'h060);
      {ext_temp_below_trip, die_over_temp} = 2'h0;
      idle(2);
      note(9'h060, 9'h060);
    end
    pulse(supply_over_limit);
    idle(5);
    note(9'h004, 9'h064);
    pulse(supply_start_trip);
    idle(1);
    note(9'h060, 9'h064);
    supply_over_limit = 1'b1;
    pulse(supply_start_trip);
    idle(1);
    note(9'h004, 9'h064);
    supply_over_limit = 1'b0;
    pulse(supply_start_trip);
    idle(1);
    note(9'h060, 9'h064);
    feedback_comp_input = 1'b1;
    supply_below_10v = 1'b1;
    idle(15);
    note(9'h000, 9'h010);
    idle(10);
    note(9'h010, 9'h070);
    feedback_comp_input = 1'b0;
    supply_below_10v = 1'b0;
    pulse(supply_start_trip);
    idle(1);
    note(9'h160, 9'h170);
    feedback_comp_input = 1'b1;
    osc_run = 1'b1;
    idle(240);
    note(9'h000, 9'h108);
    idle(50);
    note(9'h008, 9'h068);
    feedback_comp_input = 1'b0;
    osc_run = 1'b0;
    repeat (3) pulse(supply_low_trip);
    note(9'h008, 9'h008);
    pulse(supply_low_trip);
    idle(1);
    note(9'h160, 9'h168);
    on_len = 8'(($random(seed) & 8'h1F) + 10);
    valley_run = 1'b1;
    cnt = 0;
    for (run = 0; run < 8; run++)
    begin
      @(posedge aux);
      idle(2);
      note(9'h080, 9'h080);
      aux_current_over = pat[run];
      @(negedge gate);
      idle(90);
      cnt = pat[run] ? cnt + 1 : 0;
      note((cnt >= 4) ? 9'h002 : 9'h000, 9'h002);
    end
    valley_run = 1'b0;
    aux_current_over = 1'b0;
    pulse(supply_start_trip);
    idle(1);
    note(9'h060, 9'h062);
    feedback_below_pfc_off = 1'b1;
    osc_run = 1'b1;
    idle(4000);
    note(9'h000, 9'h001);
    idle(120);
    note(9'h001, 9'h001);
    complete_run();
  end
endmodule
